// File: rtl/tmcr_regs.sv
// transmitter modem configuration registers with frequency and post-tx state logic
`timescale 1ns/1ns
module tmcr_regs
   import tmcr_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire tmcr_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [23:0] base_word_a,
   input wire logic [7:0] channel_number,
   input wire logic fsk_mode,
   input wire logic tx_symbol,
   input wire logic tx_start,
   input wire logic tx_done,
   output logic [4:0] preamble_bytes,
   output logic [TMCR_SPACING_W-1:0] channel_number_spacing,
   output logic [TMCR_BASE_WORD_A_W-1:0] carrier_word,
   output logic [TMCR_DEV_W-1:0] deviation,
   output logic [TMCR_BASE_WORD_A_W-1:0] tx_base_word_a,
   output tmcr_radio_t radio_state,
   output logic preamble_restart
);

   logic [7:0] preamble_chanexp_cfg;
   logic [7:0] channel_number_spacing_mantissa;
   logic [7:0] base_word_a_deviation_cfg;
   logic [7:0] tx_completion_cfg;
   logic [7:0] next_preamble_chanexp_cfg;
   logic [7:0] next_channel_number_spacing_mantissa;
   logic [7:0] next_base_word_a_deviation_cfg;
   logic [7:0] next_tx_completion_cfg;
   logic [7:0] next_reg_rdata;
   logic next_reg_rvalid;

   logic [2:0] preamble_code;
   logic [1:0] channel_number_spacing_exp;
   logic [7:0] channel_number_spacing_mant;
   logic [2:0] dev_exp;
   logic [2:0] dev_mant;
   logic [1:0] post_tx_state_sel;

   assign preamble_code = preamble_chanexp_cfg[TMCR_PREAMBLE_LSB +: 3];
   assign channel_number_spacing_exp = preamble_chanexp_cfg[TMCR_CHANNEL_NUMBER_EXP_LSB +: 2];
   assign channel_number_spacing_mant = channel_number_spacing_mantissa;
   assign dev_exp = base_word_a_deviation_cfg[TMCR_DEV_EXP_LSB +: 3];
   assign dev_mant = base_word_a_deviation_cfg[TMCR_DEV_MANT_LSB +: 3];
   assign post_tx_state_sel = tx_completion_cfg[TMCR_POST_TX_LSB +: 2];

   // register writes and reads; masks drop unused bits, vendor bits are kept
   always_comb begin
      next_preamble_chanexp_cfg = preamble_chanexp_cfg;
      next_channel_number_spacing_mantissa = channel_number_spacing_mantissa;
      next_base_word_a_deviation_cfg = base_word_a_deviation_cfg;
      next_tx_completion_cfg = tx_completion_cfg;
      next_reg_rdata = reg_rdata;
      next_reg_rvalid = reg_req.rd;
      if (reg_req.wr) begin
         case (reg_req.addr)
            TMCR_ADDR_PREAMBLE_CHANEXP: begin
               next_preamble_chanexp_cfg = reg_req.wdata & TMCR_MASK_PREAMBLE_CHANEXP;
            end
            TMCR_ADDR_CHANNEL_NUMBER_SPACING_MANT: begin
               next_channel_number_spacing_mantissa = reg_req.wdata & TMCR_MASK_CHANNEL_NUMBER_SPACING_MANT;
            end
            TMCR_ADDR_BASE_WORD_A_DEVIATION: begin
               next_base_word_a_deviation_cfg = reg_req.wdata & TMCR_MASK_BASE_WORD_A_DEVIATION;
            end
            TMCR_ADDR_TX_COMPLETION: begin
               next_tx_completion_cfg = reg_req.wdata & TMCR_MASK_TX_COMPLETION;
            end
            default: begin
            end
         endcase
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            TMCR_ADDR_PREAMBLE_CHANEXP: next_reg_rdata = preamble_chanexp_cfg;
            TMCR_ADDR_CHANNEL_NUMBER_SPACING_MANT: next_reg_rdata = channel_number_spacing_mantissa;
            TMCR_ADDR_BASE_WORD_A_DEVIATION: next_reg_rdata = base_word_a_deviation_cfg;
            TMCR_ADDR_TX_COMPLETION: next_reg_rdata = tx_completion_cfg;
            default: next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         preamble_chanexp_cfg <= TMCR_RST_PREAMBLE_CHANEXP;
         channel_number_spacing_mantissa <= TMCR_RST_CHANNEL_NUMBER_SPACING_MANT;
         base_word_a_deviation_cfg <= TMCR_RST_BASE_WORD_A_DEVIATION;
         tx_completion_cfg <= TMCR_RST_TX_COMPLETION;
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         preamble_chanexp_cfg <= next_preamble_chanexp_cfg;
         channel_number_spacing_mantissa <= next_channel_number_spacing_mantissa;
         base_word_a_deviation_cfg <= next_base_word_a_deviation_cfg;
         tx_completion_cfg <= next_tx_completion_cfg;
         reg_rdata <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end

   // frequency arithmetic, all in crystal/2^18 steps
   logic [4:0] next_preamble_bytes;
   logic [TMCR_SPACING_W-1:0] next_channel_number_spacing;
   logic [TMCR_DEV_W-1:0] next_deviation;
   logic [TMCR_BASE_WORD_A_W-1:0] next_carrier_word;
   logic [TMCR_BASE_WORD_A_W-1:0] next_tx_base_word_a;
   logic [19:0] channel_number_offset;

   always_comb begin
      next_preamble_bytes = tmcr_preamble_bytes(preamble_code);
      next_channel_number_spacing = TMCR_SPACING_W'({1'b1, channel_number_spacing_mant}) << channel_number_spacing_exp;
      // deviation steps are twice as coarse, hence the extra low zero
      next_deviation = {(11'({1'b1, dev_mant}) << dev_exp), 1'b0};
      channel_number_offset = 20'(next_channel_number_spacing) * 20'(channel_number);
      // base word is in crystal/2^16 steps, so it moves up two places
      next_carrier_word = {1'b0, base_word_a, 2'b00} + TMCR_BASE_WORD_A_W'(channel_number_offset);
      if (!fsk_mode) begin
         next_tx_base_word_a = next_carrier_word;
      end else if (tx_symbol) begin
         next_tx_base_word_a = next_carrier_word + TMCR_BASE_WORD_A_W'(next_deviation);
      end else begin
         next_tx_base_word_a = next_carrier_word - TMCR_BASE_WORD_A_W'(next_deviation);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         preamble_bytes <= 5'h00;
         channel_number_spacing <= '0;
         deviation <= '0;
         carrier_word <= '0;
         tx_base_word_a <= '0;
      end else begin
         preamble_bytes <= next_preamble_bytes;
         channel_number_spacing <= next_channel_number_spacing;
         deviation <= next_deviation;
         carrier_word <= next_carrier_word;
         tx_base_word_a <= next_tx_base_word_a;
      end
   end

   // radio control: where to go once a packet has been sent
   tmcr_radio_t next_radio_state;
   logic next_preamble_restart;

   always_comb begin
      next_radio_state = radio_state;
      next_preamble_restart = 1'b0;
      case (radio_state)
         TMCR_IDLE, TMCR_SYNTH_READY_TX: begin
            if (tx_start) begin
               next_radio_state = TMCR_TX;
            end
         end
         TMCR_TX: begin
            if (tx_done) begin
               case (post_tx_state_sel)
                  TMCR_POST_TX_SYNTH: next_radio_state = TMCR_SYNTH_READY_TX;
                  TMCR_POST_TX_STAY: begin
                     next_radio_state = TMCR_TX;
                     next_preamble_restart = 1'b1;
                  end
                  default: next_radio_state = TMCR_IDLE;
               endcase
            end
         end
         default: next_radio_state = TMCR_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         radio_state <= TMCR_IDLE;
         preamble_restart <= 1'b0;
      end else begin
         radio_state <= next_radio_state;
         preamble_restart <= next_preamble_restart;
      end
   end

   // checks
   AST_PREAMBLE_MAP: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> preamble_bytes == tmcr_preamble_bytes($past(preamble_code)))
      else $error("preamble byte count does not match code");

   AST_CHANNEL_NUMBER_EXP_RESET: assert property (@(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> channel_number_spacing_exp == 2'b10)
      else $error("channel spacing exponent reset value wrong");

   AST_SPACING: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> channel_number_spacing ==
         ((12'h100 + 12'($past(channel_number_spacing_mant))) << $past(channel_number_spacing_exp)))
      else $error("channel spacing value wrong");

   // spacing and carrier are registered on the same edge from the same spacing value
   AST_CARRIER: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> carrier_word == {1'b0, $past(base_word_a), 2'b00} +
         TMCR_BASE_WORD_A_W'(20'(channel_number_spacing) * 20'($past(channel_number))))
      else $error("carrier word is not base plus channel offset");

   AST_DEVIATION: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> deviation == ((12'h008 + 12'($past(dev_mant))) << $past(dev_exp)) * 2)
      else $error("deviation value wrong");

   AST_FSK_SHIFT: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) && $past(fsk_mode) |->
         tx_base_word_a == ($past(tx_symbol) ? carrier_word + TMCR_BASE_WORD_A_W'(deviation)
                                      : carrier_word - TMCR_BASE_WORD_A_W'(deviation)))
      else $error("fsk frequency shift wrong");

   AST_POST_TX: assert property (@(posedge clk) disable iff (!resetn)
      radio_state == TMCR_TX && tx_done |=>
         (radio_state == TMCR_TX) == preamble_restart &&
         ($past(post_tx_state_sel) == TMCR_POST_TX_SYNTH) == (radio_state == TMCR_SYNTH_READY_TX))
      else $error("post transmit state wrong");

   AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!resetn)
      reg_req.rd && reg_req.addr == TMCR_ADDR_BASE_WORD_A_DEVIATION |=>
         reg_rvalid && reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
      else $error("unused deviation bits not zero");

   AST_VENDOR_KEEP: assert property (@(posedge clk) disable iff (!resetn)
      reg_req.wr && reg_req.addr == TMCR_ADDR_TX_COMPLETION |=>
         tx_completion_cfg == ($past(reg_req.wdata) & TMCR_MASK_TX_COMPLETION))
      else $error("tx completion register did not store write");

endmodule

// File: rtl/tmcr_pkg.sv
// constants, types and lookups shared by the transmitter modem config block
package tmcr_pkg;

   // register addresses on the serial register port
   localparam logic [5:0] TMCR_ADDR_PREAMBLE_CHANEXP = 6'h13;
   localparam logic [5:0] TMCR_ADDR_CHANNEL_NUMBER_SPACING_MANT = 6'h14;
   localparam logic [5:0] TMCR_ADDR_BASE_WORD_A_DEVIATION = 6'h15;
   localparam logic [5:0] TMCR_ADDR_TX_COMPLETION = 6'h17;

   // reset values
   localparam logic [7:0] TMCR_RST_PREAMBLE_CHANEXP = 8'h22;
   localparam logic [7:0] TMCR_RST_CHANNEL_NUMBER_SPACING_MANT = 8'hf8;
   localparam logic [7:0] TMCR_RST_BASE_WORD_A_DEVIATION = 8'h47;
   localparam logic [7:0] TMCR_RST_TX_COMPLETION = 8'h30;

   // bits that store a value; all others read zero
   localparam logic [7:0] TMCR_MASK_PREAMBLE_CHANEXP = 8'hf3;
   localparam logic [7:0] TMCR_MASK_CHANNEL_NUMBER_SPACING_MANT = 8'hff;
   localparam logic [7:0] TMCR_MASK_BASE_WORD_A_DEVIATION = 8'h77;
   localparam logic [7:0] TMCR_MASK_TX_COMPLETION = 8'h3f;

   // field positions
   localparam int TMCR_PREAMBLE_LSB = 4;
   localparam int TMCR_CHANNEL_NUMBER_EXP_LSB = 0;
   localparam int TMCR_DEV_EXP_LSB = 4;
   localparam int TMCR_DEV_MANT_LSB = 0;
   localparam int TMCR_POST_TX_LSB = 0;

   // post transmit selection codes
   localparam logic [1:0] TMCR_POST_TX_IDLE = 2'h0;
   localparam logic [1:0] TMCR_POST_TX_SYNTH = 2'h1;
   localparam logic [1:0] TMCR_POST_TX_STAY = 2'h2;

   // frequency word widths, all in crystal_base_word_a / 2^18 steps
   localparam int TMCR_SPACING_W = 12;
   localparam int TMCR_DEV_W = 12;
   localparam int TMCR_BASE_WORD_A_W = 27;

   // radio control states
   typedef enum logic [1:0] {
      TMCR_IDLE,
      TMCR_SYNTH_READY_TX,
      TMCR_TX
   } tmcr_radio_t;

   // one register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } tmcr_reg_req_t;

   // preamble code to minimum byte count
   function automatic logic [4:0] tmcr_preamble_bytes(input logic [2:0] code);
      case (code)
         3'h0: tmcr_preamble_bytes = 5'h02;
         3'h1: tmcr_preamble_bytes = 5'h03;
         3'h2: tmcr_preamble_bytes = 5'h04;
         3'h3: tmcr_preamble_bytes = 5'h06;
         3'h4: tmcr_preamble_bytes = 5'h08;
         3'h5: tmcr_preamble_bytes = 5'h0c;
         3'h6: tmcr_preamble_bytes = 5'h10;
         default: tmcr_preamble_bytes = 5'h18;
      endcase
   endfunction

endpackage

// File: verification/tmcr_regs_tb.sv
// self-checking bench for the transmitter modem configuration registers
`timescale 1ns/1ns
module tb
   import tmcr_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   tmcr_reg_req_t req = '0;
   logic [23:0] base_word_a = 24'h8a5c3f;
   logic [7:0] channel_number = 8'h00;
   logic fsk_mode = 1'b0;
   logic tx_symbol = 1'b0;
   logic tx_start = 1'b0;
   logic tx_done = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [4:0] preamble_bytes;
   logic [TMCR_SPACING_W-1:0] channel_number_spacing;
   logic [TMCR_BASE_WORD_A_W-1:0] carrier_word;
   logic [TMCR_DEV_W-1:0] deviation;
   logic [TMCR_BASE_WORD_A_W-1:0] tx_base_word_a;
   tmcr_radio_t radio_state;
   logic preamble_restart;
   int error_cnt = 0;
   int check_count = 0;
   int sp;
   int car;
   int dv;
   logic [4:0] pre_tab [0:7] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
   tmcr_radio_t exp_st [0:3] = '{TMCR_IDLE, TMCR_SYNTH_READY_TX, TMCR_TX, TMCR_IDLE};

   tmcr_regs tmcr_regs_inst (
      .clk(clk),
      .resetn(resetn),
      .reg_req(req),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .base_word_a(base_word_a),
      .channel_number(channel_number),
      .fsk_mode(fsk_mode),
      .tx_symbol(tx_symbol),
      .tx_start(tx_start),
      .tx_done(tx_done),
      .preamble_bytes(preamble_bytes),
      .channel_number_spacing(channel_number_spacing),
      .carrier_word(carrier_word),
      .deviation(deviation),
      .tx_base_word_a(tx_base_word_a),
      .radio_state(radio_state),
      .preamble_restart(preamble_restart)
   );

   // 8 ns clock
   always #4 clk = ~clk;

   // wait n rising edges, then settle past the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // compare seen against expected, count both
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one byte write, then an idle cycle so the next request starts cleanly
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      step(1);
      req = '0;
      step(1);
   endtask

   // one byte read; data and valid are looked at in the answer cycle
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      step(1);
      req = '0;
      chk(reg_rvalid, 1'b1);
      chk(reg_rdata, exp);
      step(1);
   endtask

   // verdict and end of run
   task automatic close_out;
      if (error_cnt == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      #1 resetn = 1'b1;
      step(1);
      chk(preamble_bytes, 5'h04);
      chk(channel_number_spacing, 12'h7e0);
      chk(deviation, 12'h1e0);
      chk(radio_state, TMCR_IDLE);
      rd(6'h13, 8'h22);
      rd(6'h14, 8'hf8);
      rd(6'h15, 8'h47);
      rd(6'h17, 8'h30);
      rd(6'h16, 8'h00);
      rd(6'h3f, 8'h00);
      // unused bits read zero, vendor bits keep what was written
      wr(6'h13, 8'hff);
      rd(6'h13, 8'hf3);
      wr(6'h15, 8'hff);
      rd(6'h15, 8'h77);
      wr(6'h17, 8'hff);
      rd(6'h17, 8'h3f);
      wr(6'h14, 8'h5a);
      rd(6'h14, 8'h5a);
      // every preamble code
      for (int i = 0; i < 8; i++) begin
         wr(6'h13, {1'b0, i[2:0], 4'h0});
         step(2);
         chk(preamble_bytes, pre_tab[i]);
      end
      // spacing and carrier for every exponent, mantissa at both ends
      for (int e = 0; e < 4; e++) begin
         wr(6'h13, {6'h00, e[1:0]});
         wr(6'h14, 8'(e * 85));
         channel_number = 8'(255 - e * 70);
         step(3);
         sp = (256 + e * 85) << e;
         car = base_word_a * 4 + sp * (255 - e * 70);
         chk(channel_number_spacing, sp);
         chk(carrier_word, car);
      end
      // every deviation exponent, both symbols
      fsk_mode = 1'b1;
      for (int e = 0; e < 8; e++) begin
         wr(6'h15, {1'b0, e[2:0], 1'b0, 3'(7 - e)});
         tx_symbol = e[0];
         step(2);
         dv = ((15 - e) << e) * 2;
         chk(deviation, dv);
         chk(tx_base_word_a, e[0] ? car + dv : car - dv);
      end
      fsk_mode = 1'b0;
      step(3);
      chk(tx_base_word_a, car);
      // every post-transmit selection, vendor bits kept at their reset value
      for (int s = 0; s < 4; s++) begin
         wr(6'h17, 8'h30 | 8'(s));
         tx_start = 1'b1;
         step(1);
         tx_start = 1'b0;
         chk(radio_state, TMCR_TX);
         tx_done = 1'b1;
         step(1);
         tx_done = 1'b0;
         chk(radio_state, exp_st[s]);
         chk(preamble_restart, s == 2);
         step(1);
         chk(preamble_restart, 1'b0);
         chk(radio_state, exp_st[s]);
      end
      close_out();
   end
endmodule
